// >>> overhead_word_formatter.sv
// Overhead word formatter: builds a 40-bit word and shifts it out MSB first.
// Assumes a classic Wishbone master on clk_i and a serial sink that is always ready.
// Assumes software sets FIELDS and VALUE before it writes the start bit.
// Function
// - Two-bit word type leads every word
// - Two-bit color code from software
// - Four-bit global action after color code
// - Twelve-bit registration step value from software
// - Four reserved bits fixed, software cannot set
// - Last-word flag one only in final word; the formatter sends the software-set FIELDS bit unchecked
// - Three-bit overhead type codes 100/110/111; the formatter sends the software-set FIELDS bits unchecked
// - Parity computed internally, never user-settable
// - Twenty-bit identity after color code
`timescale 1ns/1ps
`include "overhead_word_formatter_params.svh"
module overhead_word_formatter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic tx_data_o,
	output logic tx_valid_o,
	output logic tx_first_o
);
	overhead_word_formatter_pkg::word_fields_t fields_q, fields_d;
	overhead_word_formatter_pkg::tx_state_t state_q, state_d;
	logic [19:0] value_q, value_d;
	logic [39:0] word_q, word_d;
	logic [39:0] shift_q, shift_d;
	logic [5:0] count_q, count_d;
	logic [31:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	logic tx_data_q;
	logic tx_data_d;
	logic tx_valid_q;
	logic tx_valid_d;
	logic tx_first_q;
	logic tx_first_d;

	// Word assembly
	logic [27:0] info;
	logic [11:0] parity;

	// Bus decode
	logic [31:0] wmask;
	logic [31:0] status_word;
	logic req;
	logic wr;
	logic rd_go;
	logic hit_ctrl;
	logic hit_fields;
	logic hit_value;
	logic hit_status;
	logic hit_word_hi;
	logic hit_word_lo;

	// Software writes the value register as 20 bits; for increment words the low 12 bits are used
	always_comb begin
		if (fields_q.identity_kind) begin
			info = {fields_q.word_type, fields_q.color_code, value_q, fields_q.last_word, fields_q.overhead_type};
		end else begin
			info = {fields_q.word_type, fields_q.color_code, fields_q.global_action_code, value_q[11:0],
				`OWF_RESERVED_BITS, fields_q.last_word, fields_q.overhead_type};
		end
	end

	// Division by the generator polynomial; parity is never taken from the bus
	always_comb begin
		parity = 12'h000;
		for (int i = `OWF_INFO_BITS - 1; i >= 0; i--) begin
			if (info[i] ^ parity[11]) begin
				parity = {parity[10:0], 1'b0} ^ `OWF_BCH_POLY;
			end else begin
				parity = {parity[10:0], 1'b0};
			end
		end
	end

	// Byte enables widened to a bit mask
	for (genvar b = 0; b < 4; b++) begin : gen_byte_mask
		assign wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
	end

	// Full-width compares, so the word copy never aliases onto the field registers
	assign hit_ctrl = (wb_adr_i == `OWF_ADDR_CTRL);
	assign hit_fields = (wb_adr_i == `OWF_ADDR_FIELDS);
	assign hit_value = (wb_adr_i == `OWF_ADDR_VALUE);
	assign hit_status = (wb_adr_i == `OWF_ADDR_STATUS);
	assign hit_word_hi = (wb_adr_i == `OWF_ADDR_WORD_HI);
	assign hit_word_lo = (wb_adr_i == `OWF_ADDR_WORD_LO);

	// A request is taken once; the ack cycle itself never counts as a second access
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i;
	assign rd_go = wr && hit_ctrl && wb_dat_i[`OWF_CTRL_START_BIT] && wb_sel_i[0];

	// Busy drops as the last bit is launched, one cycle before tx_valid_o falls
	always_comb begin
		status_word = 32'h00000000;
		status_word[`OWF_STATUS_BUSY_BIT] = (state_q == overhead_word_formatter_pkg::ST_SHIFT);
		status_word[5:0] = count_q;
	end

	always_comb begin
		logic [31:0] f;
		logic [31:0] v;
		f = {19'h0, fields_q};
		v = {12'h000, value_q};
		fields_d = fields_q;
		value_d = value_q;
		ack_d = req;
		rdata_d = rdata_q;
		// Byte lanes merge into the old value, so a narrow write keeps the other fields
		if (wr && hit_fields) begin
			f = (f & ~wmask) | (wb_dat_i & wmask);
			fields_d = f[12:0];
		end else if (wr && hit_value) begin
			v = (v & ~wmask) | (wb_dat_i & wmask);
			value_d = v[19:0];
		end
		if (req) begin
			if (hit_fields) begin
				rdata_d = f;
			end else if (hit_value) begin
				rdata_d = v;
			end else if (hit_status) begin
				rdata_d = status_word;
			end else if (hit_word_hi) begin
				rdata_d = {24'h000000, word_q[39:32]};
			end else if (hit_word_lo) begin
				rdata_d = word_q[31:0];
			end else begin
				rdata_d = 32'h00000000;
			end
		end
	end

	// Loads only from idle: a start during a word is dropped, not queued
	always_comb begin
		state_d = state_q;
		word_d = word_q;
		shift_d = shift_q;
		count_d = count_q;
		tx_data_d = 1'b0;
		tx_valid_d = 1'b0;
		tx_first_d = 1'b0;
		case (state_q)
			overhead_word_formatter_pkg::ST_IDLE: begin
				if (rd_go) begin
					word_d = {info, parity};
					shift_d = {info, parity};
					count_d = `OWF_WORD_BITS;
					state_d = overhead_word_formatter_pkg::ST_SHIFT;
				end
			end
			overhead_word_formatter_pkg::ST_SHIFT: begin
				tx_data_d = shift_q[39];
				tx_valid_d = 1'b1;
				tx_first_d = (count_q == `OWF_WORD_BITS);
				shift_d = {shift_q[38:0], 1'b0};
				count_d = count_q - 6'h01;
				if (count_q == 6'h01) begin
					state_d = overhead_word_formatter_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = overhead_word_formatter_pkg::ST_IDLE;
			end
		endcase
	end

	// Bus-side state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fields_q <= '0;
			value_q <= 20'h00000;
			rdata_q <= 32'h00000000;
			ack_q <= 1'b0;
		end else if (ce_i) begin
			fields_q <= fields_d;
			value_q <= value_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	// Serial-side state; ce_i low also holds the bit on the pin, so the sink sees it stretched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= overhead_word_formatter_pkg::ST_IDLE;
			word_q <= 40'h0000000000;
			shift_q <= 40'h0000000000;
			count_q <= 6'h00;
			tx_data_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_first_q <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			word_q <= word_d;
			shift_q <= shift_d;
			count_q <= count_d;
			tx_data_q <= tx_data_d;
			tx_valid_q <= tx_valid_d;
			tx_first_q <= tx_first_d;
		end
	end

	// Every output comes straight from a flip-flop
	assign wb_dat_o = rdata_q;
	assign wb_ack_o = ack_q;
	assign tx_data_o = tx_data_q;
	assign tx_valid_o = tx_valid_q;
	assign tx_first_o = tx_first_q;
endmodule : overhead_word_formatter

// >>> overhead_word_formatter_params.svh
// Constants of the overhead word formatter: register offsets, field positions, codes.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef OVERHEAD_WORD_FORMATTER_PARAMS_SVH
`define OVERHEAD_WORD_FORMATTER_PARAMS_SVH
`define OWF_ADDR_CTRL 8'h00
`define OWF_ADDR_FIELDS 8'h04
`define OWF_ADDR_VALUE 8'h08
`define OWF_ADDR_STATUS 8'h0C
`define OWF_ADDR_WORD_HI 8'h10
`define OWF_ADDR_WORD_LO 8'h14
`define OWF_CTRL_START_BIT 0
`define OWF_STATUS_BUSY_BIT 31
`define OWF_WORD_BITS 6'h28
`define OWF_RESERVED_BITS 4'h0
`define OWF_OVERHEAD_TYPE_GLOBAL_ACTION 3'h4
`define OWF_OVERHEAD_TYPE_SYS_PARAM1 3'h6
`define OWF_OVERHEAD_TYPE_SYS_PARAM2 3'h7
`define OWF_BCH_POLY 12'hB29
`define OWF_INFO_BITS 28
`define OWF_PARITY_BITS 12
`endif

// >>> overhead_word_formatter_pkg.sv
// Types of the overhead word formatter.
// Assumes the params header is included by the user files.
package overhead_word_formatter_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT
	} tx_state_t;
	typedef struct packed {
		logic [1:0] word_type;
		logic [1:0] color_code;
		logic [3:0] global_action_code;
		logic [2:0] overhead_type;
		logic last_word;
		logic identity_kind;
	} word_fields_t;
endpackage : overhead_word_formatter_pkg

// >>> overhead_word_formatter_props.sv
// Checker for the overhead word formatter: bus answer and serial framing.
// Assumes ce_i is high while checked and one clock domain.
`timescale 1ns/1ps
module overhead_word_formatter_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic tx_valid_o,
	input wire logic tx_first_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [6:0] cnt_q;
	// Counts bit cycles so a restarted or cut word shows at the fall of valid
	always_ff @(posedge clk_i) begin
		cnt_q <= (rst_i || !tx_valid_o) ? 7'h00 : cnt_q + 7'h01;
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_start;
		s_req ##0 wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[0] && !tx_valid_o;
	endsequence
	a_ack_latency: assert property (s_req |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
	a_ctrl_reads_zero: assert property (s_req ##0 !wb_we_i && wb_adr_i == 8'h00 |=> wb_dat_o == 32'h0)
		else $error("control reads nonzero");
	a_reset_quiet: assert property ($past(rst_i) |-> !wb_ack_o && !tx_valid_o) else $error("busy after reset");
	a_start_launch: assert property (s_start |-> ##[1:3] tx_first_o) else $error("start lost");
	a_first_leads: assert property ($rose(tx_valid_o) |-> tx_first_o) else $error("first missing");
	a_first_once: assert property (tx_first_o |-> tx_valid_o && cnt_q == 7'h00) else $error("first misplaced");
	a_word_length: assert property ($fell(tx_valid_o) |-> cnt_q == 7'h28) else $error("word not 40 bits");
endmodule : overhead_word_formatter_props
bind overhead_word_formatter overhead_word_formatter_props props (.*);

// >>> mobile_station_model.sv
// Receiving station: gathers one serial word, MSB first.
// Assumes the sink is always ready, as the formatter expects.
`timescale 1ns/1ps
module mobile_station_model (
	input wire logic clk_i,
	input wire logic d_i,
	input wire logic v_i,
	input wire logic f_i,
	output logic [39:0] word_o,
	output logic [7:0] nbits_o
);
	// A first bit clears the old word so a short word cannot pass as whole
	always_ff @(posedge clk_i) begin
		if (v_i) begin
			word_o <= {f_i ? 39'h0 : word_o[38:0], d_i};
			nbits_o <= f_i ? 8'h01 : nbits_o + 8'h01;
		end
	end
endmodule : mobile_station_model

// >>> testbench.sv
// Bench: builds words over Wishbone and compares register copy and received serial word.
// Assumes the formatter answers every access and shifts without back-pressure.
`timescale 1ns/1ps
`include "overhead_word_formatter_params.svh"
module testbench;
	logic clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00, nb;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic wb_ack_o, tx_data_o, tx_valid_o, tx_first_o;
	logic [39:0] rx, w, e;
	int errors = 0, n_tests = 0;
	logic [12:0] f[3] = '{13'h1850, 13'h021B, 13'h15FC};
	logic [19:0] v[3] = '{20'hFF064, 20'hA5C3E, 20'h00FFF};
	always #2.5 clk_i = ~clk_i;
	overhead_word_formatter dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_first_o(tx_first_o));
	mobile_station_model ms (.clk_i, .d_i(tx_data_o), .v_i(tx_valid_o), .f_i(tx_first_o), .word_o(rx), .nbits_o(nb));
	task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
	endtask : bus
	task chk(input logic [39:0] s, input logic [39:0] x);
		n_tests++;
		if (s !== x) begin
			errors++;
			$display("BAD t=%0t seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task test_done;
		$display("compares %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done
	// Software never supplies reserved or parity bits, so both come from here
	function automatic logic [39:0] ex(logic [12:0] g, logic [19:0] d);
		logic [27:0] i;
		logic [11:0] p;
		i = g[0] ? {g[12:9], d, g[1], g[4:2]} : {g[12:5], d[11:0], `OWF_RESERVED_BITS, g[1], g[4:2]};
		p = 12'h000;
		for (int k = 27; k >= 0; k--) p = {p[10:0], 1'b0} ^ ((i[k] ^ p[11]) ? `OWF_BCH_POLY : 12'h000);
		return {i, p};
	endfunction : ex
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		for (int k = 0; k < 3; k++) begin
			bus(1, 8'h04, 32'(f[k]));
			bus(1, 8'h08, 32'(v[k]));
			bus(0, 8'h04, 32'h0);
			chk(40'(q), 40'(f[k]));
			bus(1, 8'h00, 32'h1);
			// Second start lands mid-word and must be ignored
			bus(1, 8'h00, 32'h1);
			e = ex(f[k], v[k]);
			do bus(0, 8'h0C, 32'h0); while (q[31] !== 1'b0);
			chk(40'(q), 40'h0);
			bus(0, 8'h10, 32'h0);
			w[39:32] = q[7:0];
			bus(0, 8'h14, 32'h0);
			w[31:0] = q;
			chk(w, e);
			chk(rx, e);
			chk(40'(nb), 40'h28);
			$display("word test %0d done", k);
		end
		bus(0, 8'h20, 32'h0);
		chk(40'(q), 40'h0);
		bus(0, 8'h00, 32'h0);
		chk(40'(q), 40'h0);
		$display("access test done");
		test_done;
	end
	initial begin
		#20000;
		errors++;
		test_done;
	end
endmodule : testbench
